//--- core/alcor_regs.sv
`timescale 1ns/1ps
module alcor_regs
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_B,
	// Register port
	input  wire logic [15:0] ADDR,
	input  wire logic [7:0]  WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [7:0]  RDATA,
	// Analog loop two calibration override
	output logic      [1:0]  LOOP_TWO_CAL_LEVEL,
	output logic             LOOP_TWO_CAL_MANUAL,
	// Analog loop three calibration override
	output logic      [1:0]  LOOP_THREE_CAL_LEVEL,
	output logic             LOOP_THREE_CAL_MANUAL,
	// Access gate state
	output logic             CAL_ACCESS_OPEN
);
	logic [7:0] gate_reg, gate_next;
	logic [7:0] rdata_reg, rdata_next;
	logic       open_reg, open_next;
	logic       commit_reg, commit_next;
	alcor_pkg::alcor_state_e state_reg, state_next;
	logic       access_ok;
	logic       wr2, wr3;
	logic [2:0] staged2, staged3;
	logic       pend2, pend3;

	// Only the exact unlock code opens the gate
	assign access_ok = (gate_reg == alcor_pkg::GATE_UNLOCK);
	assign wr2 = WR && access_ok && (ADDR == alcor_pkg::ADDR_LOOP2_OVR);
	assign wr3 = WR && access_ok && (ADDR == alcor_pkg::ADDR_LOOP3_OVR);

	// Gate register and commit sequencer
	always_comb
	begin
		gate_next   = gate_reg;
		state_next  = state_reg;
		commit_next = 1'b0;
		if (WR && ADDR == alcor_pkg::ADDR_GATE)
			gate_next = WDATA;
		case (state_reg)
			alcor_pkg::ALCOR_IDLE:
			begin
				// Other update values are ignored
				if (WR && ADDR == alcor_pkg::ADDR_UPDATE && WDATA == alcor_pkg::UPDATE_CMD)
				begin
					state_next  = alcor_pkg::ALCOR_COMMIT;
					commit_next = 1'b1;
				end
			end
			alcor_pkg::ALCOR_COMMIT:
			begin
				// Back-to-back updates still commit
				state_next = alcor_pkg::ALCOR_IDLE;
				if (WR && ADDR == alcor_pkg::ADDR_UPDATE && WDATA == alcor_pkg::UPDATE_CMD)
				begin
					state_next  = alcor_pkg::ALCOR_COMMIT;
					commit_next = 1'b1;
				end
			end
			default:
				state_next = alcor_pkg::ALCOR_IDLE;
		endcase
		open_next = (gate_next == alcor_pkg::GATE_UNLOCK);
	end

	// Read mux; reserved and unmapped read zero
	always_comb
	begin
		rdata_next = alcor_pkg::READ_ZERO;
		if (RD)
		begin
			case (ADDR)
				alcor_pkg::ADDR_GATE:      rdata_next = gate_reg;
				alcor_pkg::ADDR_LOOP2_OVR: rdata_next = {alcor_pkg::RSVD_ZERO, staged2};
				alcor_pkg::ADDR_LOOP3_OVR: rdata_next = {alcor_pkg::RSVD_ZERO, staged3};
				alcor_pkg::ADDR_STATUS:
				begin
					rdata_next[alcor_pkg::ST_GATE_BIT]  = access_ok;
					rdata_next[alcor_pkg::ST_PEND2_BIT] = pend2;
					rdata_next[alcor_pkg::ST_PEND3_BIT] = pend3;
				end
				default:                   rdata_next = alcor_pkg::READ_ZERO;
			endcase
		end
	end

	// Registers of the control side
	always_ff @(posedge CLK or negedge RST_B)
	begin
		if (!RST_B)
		begin
			gate_reg   <= alcor_pkg::GATE_RESET;
			state_reg  <= alcor_pkg::ALCOR_IDLE;
			commit_reg <= 1'b0;
			open_reg   <= 1'b0;
			rdata_reg  <= alcor_pkg::READ_ZERO;
		end
		else
		begin
			gate_reg   <= gate_next;
			state_reg  <= state_next;
			commit_reg <= commit_next;
			open_reg   <= open_next;
			rdata_reg  <= rdata_next;
		end
	end

	// Commit lands one cycle after the update write; a staging write
	// in that same cycle is too late for this commit and stays pending
	alcor_loop_ovr u_loop2
	(
		.clk       (CLK),
		.rst_b     (RST_B),
		.wr_en     (wr2),
		.wr_data   (WDATA),
		.commit    (commit_reg),
		.staged    (staged2),
		.pending   (pend2),
		.level     (LOOP_TWO_CAL_LEVEL),
		.manual_en (LOOP_TWO_CAL_MANUAL)
	);

	alcor_loop_ovr u_loop3
	(
		.clk       (CLK),
		.rst_b     (RST_B),
		.wr_en     (wr3),
		.wr_data   (WDATA),
		.commit    (commit_reg),
		.staged    (staged3),
		.pending   (pend3),
		.level     (LOOP_THREE_CAL_LEVEL),
		.manual_en (LOOP_THREE_CAL_MANUAL)
	);

	assign RDATA           = rdata_reg;
	assign CAL_ACCESS_OPEN = open_reg;
endmodule // alcor_regs

//--- core/alcor_pkg.sv
package alcor_pkg;
	// Register addresses (byte addresses on the 16-bit register port)
	localparam logic [15:0] ADDR_UPDATE    = 16'h000F;
	localparam logic [15:0] ADDR_GATE      = 16'h0FFF;
	localparam logic [15:0] ADDR_LOOP2_OVR = 16'h1688;
	localparam logic [15:0] ADDR_LOOP3_OVR = 16'h1788;
	localparam logic [15:0] ADDR_STATUS    = 16'h1800;

	// Values with a meaning
	localparam logic [7:0]  UPDATE_CMD     = 8'h01;
	localparam logic [7:0]  GATE_UNLOCK    = 8'hF9;
	localparam logic [7:0]  GATE_RESET     = 8'h00;

	// Override register fields
	localparam int          EN_BIT         = 0;
	localparam int          LVL_LSB        = 1;
	localparam int          LVL_MSB        = 2;
	localparam logic [1:0]  LVL_RESET      = 2'h0;
	localparam logic        EN_RESET       = 1'b0;
	localparam logic [4:0]  RSVD_ZERO      = 5'h00;

	// Status register fields
	localparam int          ST_GATE_BIT    = 0;
	localparam int          ST_PEND2_BIT   = 1;
	localparam int          ST_PEND3_BIT   = 2;
	localparam logic [7:0]  READ_ZERO      = 8'h00;

	// Commit sequencer states
	typedef enum logic [1:0] {
		ALCOR_IDLE   = 2'b00,
		ALCOR_COMMIT = 2'b01
	} alcor_state_e;
endpackage

//--- core/alcor_loop_ovr.sv
`timescale 1ns/1ps
// One loop's staged and active calibration override
module alcor_loop_ovr
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// Staging write, already gated
	input  wire logic       wr_en,
	input  wire logic [7:0] wr_data,
	// Commit strobe
	input  wire logic       commit,
	// Staged value for readback
	output logic      [2:0] staged,
	output logic            pending,
	// Applied value to the analog loop
	output logic      [1:0] level,
	output logic            manual_en
);
	logic [1:0] stg_lvl_reg, stg_lvl_next;
	logic       stg_en_reg, stg_en_next;
	logic [1:0] act_lvl_reg, act_lvl_next;
	logic       act_en_reg, act_en_next;
	logic       pend_reg, pend_next;

	// Staging takes writes; commit copies staged to active
	always_comb
	begin
		stg_lvl_next = stg_lvl_reg;
		stg_en_next  = stg_en_reg;
		act_lvl_next = act_lvl_reg;
		act_en_next  = act_en_reg;
		pend_next    = pend_reg;
		if (wr_en)
		begin
			stg_lvl_next = wr_data[alcor_pkg::LVL_MSB:alcor_pkg::LVL_LSB];
			stg_en_next  = wr_data[alcor_pkg::EN_BIT];
		end
		if (commit)
		begin
			act_lvl_next = stg_lvl_reg;
			act_en_next  = stg_en_reg;
			pend_next    = 1'b0;
		end
		// A write in the commit cycle stays pending; set beats clear
		if (wr_en)
			pend_next = 1'b1;
	end

	// Reset leaves automatic selection in charge
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stg_lvl_reg <= alcor_pkg::LVL_RESET;
			stg_en_reg  <= alcor_pkg::EN_RESET;
			act_lvl_reg <= alcor_pkg::LVL_RESET;
			act_en_reg  <= alcor_pkg::EN_RESET;
			pend_reg    <= 1'b0;
		end
		else
		begin
			stg_lvl_reg <= stg_lvl_next;
			stg_en_reg  <= stg_en_next;
			act_lvl_reg <= act_lvl_next;
			act_en_reg  <= act_en_next;
			pend_reg    <= pend_next;
		end
	end

	assign staged    = {stg_lvl_reg, stg_en_reg};
	assign pending   = pend_reg;
	assign level     = act_lvl_reg;
	assign manual_en = act_en_reg;
endmodule // alcor_loop_ovr

//--- sim/alcor_regs_properties.sv
`timescale 1ns/1ps
// Port-level checks of the override register bank
module alcor_regs_chk
(
	// Clock and reset
	input wire logic        CLK,
	input wire logic        RST_B,
	// Register port
	input wire logic [15:0] ADDR,
	input wire logic [7:0]  WDATA,
	input wire logic        WR,
	input wire logic        RD,
	input wire logic [7:0]  RDATA,
	// Applied values and gate
	input wire logic [1:0]  LOOP_TWO_CAL_LEVEL,
	input wire logic        LOOP_TWO_CAL_MANUAL,
	input wire logic [1:0]  LOOP_THREE_CAL_LEVEL,
	input wire logic        LOOP_THREE_CAL_MANUAL,
	input wire logic        CAL_ACCESS_OPEN
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_B);
	// Read data only stands after a read
	property p_rd_idle; !$past(RD) |-> RDATA == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
	property p_open;
		WR && ADDR == alcor_pkg::ADDR_GATE |=> CAL_ACCESS_OPEN == ($past(WDATA) == 8'hF9);
	endproperty
	a_open: assert property (p_open) else $error("gate state wrong");
	property p_gate_rd;
		RD && ADDR == alcor_pkg::ADDR_GATE && CAL_ACCESS_OPEN |=> RDATA == 8'hF9;
	endproperty
	a_gate_rd: assert property (p_gate_rd) else $error("gate readback wrong");
	property p_rsvd;
		RD && (ADDR == 16'h1688 || ADDR == 16'h1788) |=> RDATA[7:3] == 5'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	// Applied values move only two edges after a valid update write
	property p_chg;
		$changed({LOOP_TWO_CAL_LEVEL, LOOP_TWO_CAL_MANUAL, LOOP_THREE_CAL_LEVEL,
			LOOP_THREE_CAL_MANUAL}) |-> $past(WR && ADDR == 16'h000F && WDATA == 8'h01, 2);
	endproperty
	a_chg: assert property (p_chg) else $error("applied value moved without update");
	property p_commit;
		(WR && ADDR == 16'h1688 && CAL_ACCESS_OPEN) ##1 (WR && ADDR == 16'h000F && WDATA == 8'h01)
			|-> ##2 {LOOP_TWO_CAL_LEVEL, LOOP_TWO_CAL_MANUAL} == $past(WDATA[2:0], 3);
	endproperty
	a_commit: assert property (p_commit) else $error("commit not applied");
	property p_ovr_rd;
		(WR && ADDR == 16'h1688 && CAL_ACCESS_OPEN) ##1 (RD && ADDR == 16'h1688)
			|=> RDATA == {5'h00, $past(WDATA[2:0], 2)};
	endproperty
	a_ovr_rd: assert property (p_ovr_rd) else $error("override readback wrong");
	property p_unmapped;
		RD && !(ADDR inside {16'h000F, 16'h0FFF, 16'h1688, 16'h1788, 16'h1800}) |=> RDATA == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule // alcor_regs_chk

bind alcor_regs alcor_regs_chk u_chk (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA),
	.WR(WR), .RD(RD), .RDATA(RDATA), .LOOP_TWO_CAL_LEVEL(LOOP_TWO_CAL_LEVEL),
	.LOOP_TWO_CAL_MANUAL(LOOP_TWO_CAL_MANUAL), .LOOP_THREE_CAL_LEVEL(LOOP_THREE_CAL_LEVEL),
	.LOOP_THREE_CAL_MANUAL(LOOP_THREE_CAL_MANUAL), .CAL_ACCESS_OPEN(CAL_ACCESS_OPEN));

//--- sim/tb_alcor_regs.sv
`timescale 1ns/1ps
// Register-port sequences for the override bank
module tb_alcor_regs;
	logic        CLK = 1'b0;
	logic        RST_B = 1'b0;
	logic [15:0] ADDR = 16'h0000;
	logic [7:0]  WDATA = 8'h00;
	logic        WR = 1'b0;
	logic        RD = 1'b0;
	logic [7:0]  RDATA;
	logic [1:0]  LVL2;
	logic [1:0]  LVL3;
	logic        MAN2;
	logic        MAN3;
	logic        OPEN;
	int          n_fail = 0;
	int          n_tests = 0;

	always #4 CLK = ~CLK;

	alcor_regs u_dut (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .LOOP_TWO_CAL_LEVEL(LVL2), .LOOP_TWO_CAL_MANUAL(MAN2),
		.LOOP_THREE_CAL_LEVEL(LVL3), .LOOP_THREE_CAL_MANUAL(MAN3), .CAL_ACCESS_OPEN(OPEN));

	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// Strobe stays up so writes can run back to back
	task wr(input logic [15:0] a, input logic [7:0] d);
		ADDR <= a; WDATA <= d; WR <= 1'b1; RD <= 1'b0;
		@(posedge CLK);
	endtask
	task idle;
		WR <= 1'b0; RD <= 1'b0;
		@(posedge CLK);
	endtask
	// Mid-run reset stands in for a new power cycle, so loop two is written once per cycle
	task pwr;
		RST_B <= 1'b0;
		repeat (2) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		ADDR <= a; RD <= 1'b1; WR <= 1'b0;
		@(posedge CLK);
		RD <= 1'b0;
		#1 chk("rdata", RDATA, e);
		@(posedge CLK);
	endtask
	// Update write, then wait out the two-edge apply delay
	task cmt(input logic [7:0] c);
		wr(16'h000F, c);
		idle;
		repeat (2) @(posedge CLK);
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Watchdog far beyond the roughly 90 cycles needed
	initial
	begin
		#20000;
		n_fail++;
		results;
	end

	initial
	begin
		repeat (10) @(posedge CLK);
		RST_B <= 1'b1;
		@(posedge CLK);
		rd(16'h1688, 8'h00);
		rd(16'h1788, 8'h00);
		wr(16'h1688, 8'h03);
		cmt(8'h01);
		chk("man2", {7'h00, MAN2}, 8'h00);
		rd(16'h1688, 8'h00);
		$display("locked test done");
		wr(16'h0FFF, 8'hF9);
		idle;
		chk("open", {7'h00, OPEN}, 8'h01);
		wr(16'h1688, 8'hFB);
		rd(16'h1688, 8'h03);
		rd(16'h1800, 8'h03);
		cmt(8'h02);
		chk("man2", {7'h00, MAN2}, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			pwr;
			chk("man2", {7'h00, MAN2}, 8'h00);
			wr(16'h0FFF, 8'hF9);
			wr(16'h1688, 8'(i * 2 + 1));
			cmt(8'h01);
			chk("lvl2", {6'h00, LVL2}, 8'(i));
			chk("man2", {7'h00, MAN2}, 8'h01);
			rd(16'h1800, 8'h01);
		end
		wr(16'h0FFF, 8'h00);
		idle;
		chk("open", {7'h00, OPEN}, 8'h00);
		wr(16'h1788, 8'h03);
		rd(16'h1788, 8'h00);
		wr(16'h0FFF, 8'hF9);
		wr(16'h1788, 8'h05);
		cmt(8'h01);
		chk("lvl3", {6'h00, LVL3}, 8'h02);
		chk("man3", {7'h00, MAN3}, 8'h01);
		chk("lvl2", {6'h00, LVL2}, 8'h03);
		rd(16'h0FFF, 8'hF9);
		rd(16'h1234, 8'h00);
		$display("unlocked test done");
		results;
	end
endmodule // tb_alcor_regs
